/* rtl/scaler_stream_map.svh */
// Constants for the scaler stream port: widths and field positions.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef SCALER_STREAM_MAP_SVH
`define SCALER_STREAM_MAP_SVH
`define PIX_WIDTH 24
`define DIM_WIDTH 16
`define PITCH_WIDTH 24
`define PITCH_FRAC 12
`define PITCH_ONE 24'h001000
`endif

/* rtl/scaler_stream_pkg.sv */
// Types shared by the scaler stream port files.
// Assumes the map header is compiled first.
`include "scaler_stream_map.svh"
package scaler_stream_pkg;
	typedef enum logic [1:0] {
		SYNC_HUNT = 2'b00,
		SYNC_RUN = 2'b01
	} syncState_t;
endpackage : scaler_stream_pkg

/* rtl/stream_out_stage.sv */
// Output register stage for a valid-ready pixel stream with sync flags.
// Assumes producer and consumer on clk_sys; holds data while stalled.
`timescale 1ns/100ps
`default_nettype none
`include "scaler_stream_map.svh"
module stream_out_stage #(
	parameter int PW = `PIX_WIDTH
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [PW-1:0] inPixel,
	input wire logic inFrameStart,
	input wire logic inLineStart,
	output logic outValid,
	input wire logic outReady,
	output logic [PW-1:0] outPixel,
	output logic outFrameStart,
	output logic outLineStart
);
	logic validReg;
	logic [PW-1:0] pixelReg;
	logic frameReg;
	logic lineReg;
	wire loadEn = inValid && inReady;

	// Accept whenever empty or being drained in the same cycle
	assign inReady = !validReg || outReady;
	assign outValid = validReg;
	assign outPixel = pixelReg;
	assign outFrameStart = frameReg;
	assign outLineStart = lineReg;

	// Valid flag; cleared only by a completed transfer
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			validReg <= 1'b0;
		end else if (inReady) begin
			validReg <= inValid;
		end
	end

	// Payload moves only on load, so it holds during a stall
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pixelReg <= '0;
			frameReg <= 1'b0;
			lineReg <= 1'b0;
		end else if (loadEn) begin
			pixelReg <= inPixel;
			frameReg <= inFrameStart;
			lineReg <= inLineStart;
		end
	end
endmodule : stream_out_stage
`default_nettype wire

/* rtl/video_scaler_stream_port.sv */
// Framed pixel stream port of a two-dimensional video scaler.
// Assumes source and sink logic on clk_sys; geometry inputs stay stable
// while a frame runs, and a reset is applied when they change.
// Resampling is nearest-neighbour from a single line store; a full
// polyphase filter would replace the selection path below.
`timescale 1ns/100ps
`default_nettype none
`include "scaler_stream_map.svh"
module video_scaler_stream_port #(
	parameter int PW = `PIX_WIDTH,
	parameter int DW = `DIM_WIDTH,
	parameter int LINE_WIDTH = 1024,
	parameter int LW = 10
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [`PITCH_WIDTH-1:0] pitchX,
	input wire logic [`PITCH_WIDTH-1:0] pitchY,
	input wire logic [DW-1:0] inPixelsPerLine,
	input wire logic [DW-1:0] inLinesPerFrame,
	input wire logic [DW-1:0] outPixelsPerLine,
	input wire logic [DW-1:0] outLinesPerFrame,
	input wire logic [PW-1:0] pixIn,
	input wire logic pixInFrameStart,
	input wire logic pixInLineStart,
	input wire logic pixInValid,
	output logic pixInReady,
	output logic [PW-1:0] pixOut,
	output logic pixOutFrameStart,
	output logic pixOutLineStart,
	output logic pixOutValid,
	input wire logic pixOutReady
);
	scaler_stream_pkg::syncState_t syncReg;
	scaler_stream_pkg::syncState_t syncNext;
	logic [PW-1:0] lineMem [LINE_WIDTH];
	logic [DW-1:0] inColReg;
	logic [DW-1:0] inRowReg;
	logic lineFullReg;
	logic readyReg;
	logic [DW-1:0] outColReg;
	logic [DW-1:0] outRowReg;
	logic [`PITCH_WIDTH-1:0] accXReg;
	logic [`PITCH_WIDTH-1:0] accYReg;
	logic emitReg;
	logic stageReady;
	logic [PW-1:0] emitPixel;

	// Position at its origin; shared by both output sync flags
	function automatic logic atOrigin(input logic [DW-1:0] pos);
		return pos == '0;
	endfunction : atOrigin

	// Only a valid handshake counts; flags are ignored otherwise
	wire inTake = pixInValid && readyReg;
	wire frameMark = inTake && pixInFrameStart && pixInLineStart;
	wire lineMark = inTake && pixInLineStart && !pixInFrameStart;
	wire running = (syncReg == scaler_stream_pkg::SYNC_RUN);
	wire acceptPix = inTake && (running || frameMark);

	// Output geometry bookkeeping
	wire emitFire = emitReg && stageReady;
	wire lastCol = (outColReg == outPixelsPerLine - 1'b1);
	wire lastRow = (outRowReg == outLinesPerFrame - 1'b1);
	wire [`PITCH_WIDTH-1:0] accXNext = accXReg + pitchX;
	wire [`PITCH_WIDTH-1:0] accYNext = accYReg + pitchY;
	// Integer part of each accumulator, zero extended to a position
	wire [DW-1:0] srcRow = DW'(accYReg[`PITCH_WIDTH-1:`PITCH_FRAC]);
	wire [DW-1:0] srcCol = DW'(accXReg[`PITCH_WIDTH-1:`PITCH_FRAC]);
	wire [LW-1:0] readIdx = srcCol[LW-1:0];
	// A sync mark always lands at column zero, whatever the count says
	wire [LW-1:0] writeIdx = (frameMark || lineMark) ? '0 : inColReg[LW-1:0];
	wire lastInCol = (inColReg == inPixelsPerLine - 1'b1);
	wire lastInRow = (inRowReg == inLinesPerFrame - 1'b1);

	// Emit when the buffered line is the source row for this output row
	wire rowMatch = lineFullReg && (inRowReg == srcRow);
	wire rowBehind = lineFullReg && (srcRow > inRowReg) && !lastInRow;

	assign emitPixel = lineMem[readIdx];

	// Sync flags of the pixel about to be staged
	wire outLineFirst = atOrigin(outColReg);
	wire outFrameFirst = outLineFirst && atOrigin(outRowReg);

	// Hunt for a clean frame start after reset, then run
	always_comb begin
		syncNext = syncReg;
		unique case (syncReg)
			scaler_stream_pkg::SYNC_HUNT: begin
				if (frameMark) begin
					syncNext = scaler_stream_pkg::SYNC_RUN;
				end
			end
			scaler_stream_pkg::SYNC_RUN: begin
				if (emitFire && lastCol && lastRow) begin
					syncNext = scaler_stream_pkg::SYNC_HUNT;
				end
			end
			default: syncNext = scaler_stream_pkg::SYNC_HUNT;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			syncReg <= scaler_stream_pkg::SYNC_HUNT;
		end else begin
			syncReg <= syncNext;
		end
	end

	// Line store write; storage is flip-flops indexed by column
	always_ff @(posedge clk_sys) begin
		if (acceptPix) begin
			lineMem[writeIdx] <= pixIn;
		end
	end

	// Input position; a line-start mark resynchronises the column
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			inColReg <= '0;
			inRowReg <= '0;
			lineFullReg <= 1'b0;
		end else if (frameMark && !running) begin
			inColReg <= DW'(1);
			inRowReg <= '0;
			lineFullReg <= lastInCol;
		end else if (acceptPix) begin
			if (lineMark) begin
				inColReg <= DW'(1);
				inRowReg <= inRowReg + 1'b1;
				lineFullReg <= 1'b0;
			end else if (lastInCol) begin
				inColReg <= '0;
				lineFullReg <= 1'b1;
			end else begin
				inColReg <= inColReg + 1'b1;
			end
		end else if (!running) begin
			// Output frame done: free the store, else ready stays low forever
			lineFullReg <= 1'b0;
		end else if (rowBehind && !emitReg) begin
			lineFullReg <= 1'b0; // Release the line so the next one loads
		end
	end

	// Stall input while a full line waits to be scaled out
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			readyReg <= 1'b0;
		end else begin
			readyReg <= !(lineFullReg || (acceptPix && lastInCol)) || (rowBehind && !emitReg);
		end
	end

	// Output walk over the scaled frame; one output frame per input frame that starts with a frame-start mark
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			outColReg <= '0;
			outRowReg <= '0;
			accXReg <= '0;
			accYReg <= '0;
			emitReg <= 1'b0;
		end else begin
			emitReg <= running && rowMatch && !(emitFire && lastCol);
			if (frameMark && !running) begin
				outColReg <= '0;
				outRowReg <= '0;
				accXReg <= '0;
				accYReg <= '0;
			end else if (emitFire) begin
				if (lastCol) begin
					outColReg <= '0;
					accXReg <= '0;
					outRowReg <= lastRow ? '0 : outRowReg + 1'b1;
					accYReg <= lastRow ? '0 : accYNext;
				end else begin
					outColReg <= outColReg + 1'b1;
					accXReg <= accXNext;
				end
			end
		end
	end

	// Registered output stage holds the pixel while the sink stalls
	stream_out_stage #(
		.PW(PW)
	) outStage (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.inValid(emitReg),
		.inReady(stageReady),
		.inPixel(emitPixel),
		.inFrameStart(outFrameFirst),
		.inLineStart(outLineFirst),
		.outValid(pixOutValid),
		.outReady(pixOutReady),
		.outPixel(pixOut),
		.outFrameStart(pixOutFrameStart),
		.outLineStart(pixOutLineStart)
	);

	assign pixInReady = readyReg;
endmodule : video_scaler_stream_port
`default_nettype wire

/* bench/scaler_stream_monitor.sv */
// Checker of the scaler stream port handshakes and sync flags.
// Assumes the bind below; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module scaler_stream_monitor #(parameter int PW = 24, parameter int DW = 16) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic pixInValid,
	input wire logic pixInReady,
	input wire logic pixInFrameStart,
	input wire logic pixOutValid,
	input wire logic pixOutReady,
	input wire logic pixOutFrameStart,
	input wire logic pixOutLineStart,
	input wire logic [PW-1:0] pixOut,
	input wire logic [DW-1:0] outPixelsPerLine
);
	logic seen_reg;
	logic [DW-1:0] col_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence stalled; pixOutValid && !pixOutReady; endsequence
	sequence lateLine; pixOutValid && pixOutLineStart && !pixOutFrameStart; endsequence
	// Frame start seen at input; output column since line start
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			seen_reg <= 1'b0;
			col_reg <= '0;
		end else begin
			seen_reg <= seen_reg | (pixInValid & pixInReady & pixInFrameStart);
			if (pixOutValid && pixOutReady) col_reg <= pixOutLineStart ? DW'(1) : col_reg + 1'b1;
		end
	end
	a_stall_data: assert property (stalled |=> $stable(pixOut)) else $error("pixel moved");
	a_stall_flags: assert property (stalled |=> $stable({pixOutFrameStart, pixOutLineStart}))
		else $error("flags moved");
	a_stall_valid: assert property (stalled |=> pixOutValid) else $error("valid withdrawn");
	a_hunt_quiet: assert property (!seen_reg |-> !pixOutValid) else $error("early output");
	a_ready_rise: assert property ($rose(reset_n) |=> pixInReady) else $error("not ready");
	a_frame_line: assert property (pixOutValid && pixOutFrameStart |-> pixOutLineStart)
		else $error("frame start lacks line start");
	a_line_first: assert property (pixOutValid && col_reg == outPixelsPerLine |-> pixOutLineStart)
		else $error("line start missing");
	a_line_late: assert property (lateLine |-> col_reg == outPixelsPerLine)
		else $error("line start misplaced");
endmodule : scaler_stream_monitor
bind video_scaler_stream_port scaler_stream_monitor #(.PW(PW), .DW(DW)) i_mon(.clk_sys, .reset_n,
	.pixInValid, .pixInReady, .pixInFrameStart, .pixOutValid, .pixOutReady, .pixOutFrameStart,
	.pixOutLineStart, .pixOut, .outPixelsPerLine);
`default_nettype wire

/* bench/frame_source.sv */
// Upstream frame source: offers ppl x LPF pixels per go pulse.
// Assumes go is one cycle wide; mark low sends an unmarked frame.
`timescale 1ns/100ps
`default_nettype none
module frame_source #(parameter int LPF = 2) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic go,
	input wire logic gap,
	input wire logic mark,
	input wire logic pixInReady,
	input wire logic [15:0] ppl,
	output logic [23:0] pixIn,
	output logic pixInFrameStart,
	output logic pixInLineStart,
	output logic pixInValid,
	output logic busy
);
	int idx;
	// Offer a pixel, hold it until taken; idle lines churn
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{pixInValid, busy, pixInFrameStart, pixInLineStart} <= 4'h0;
			pixIn <= 24'h000000;
			idx <= 0;
		end else begin
			if (!pixInValid || pixInReady) begin
				if (busy && !gap) begin
					pixInValid <= 1'b1;
					pixIn <= 24'(idx * 24'h010101);
					pixInFrameStart <= mark && idx == 0;
					pixInLineStart <= mark && idx % ppl == 0;
					idx <= idx + 1;
					busy <= idx + 1 < ppl * LPF;
				end else begin
					// Stale flags may read high, so the design must gate them
					pixInValid <= 1'b0;
					pixIn <= ~pixIn;
					{pixInFrameStart, pixInLineStart} <= {gap, gap};
				end
			end
			if (go) begin
				busy <= 1'b1;
				idx <= 0;
			end
		end
	end
endmodule : frame_source
`default_nettype wire

/* bench/video_scaler_stream_port_bench.sv */
// Bench: frame source, random sink stalls, two input geometries.
// Assumes the design hunts for a frame start after each reset.
`timescale 1ns/100ps
`default_nettype none
module video_scaler_stream_port_bench;
	logic clk_sys = 1'b0, reset_n = 1'b0, go = 1'b0, gap = 1'b0, mark = 1'b0, pixOutReady = 1'b0;
	logic pixInValid, pixInReady, pixInFrameStart, pixInLineStart, busy;
	logic pixOutValid, pixOutFrameStart, pixOutLineStart;
	logic [23:0] pixIn, pixOut, pitchX = 24'h001000;
	logic [15:0] ppl = 16'h0004;
	logic [31:0] seed = 32'h0000005D;
	int n_fail = 0, comparisons = 0, nOut = 0, nFs = 0;
	always #12.5 clk_sys = ~clk_sys;
	frame_source i_src(.clk_sys, .reset_n, .go, .gap, .mark, .pixInReady, .ppl, .pixIn,
		.pixInFrameStart, .pixInLineStart, .pixInValid, .busy);
	video_scaler_stream_port i_dut(.clk_sys, .reset_n, .pitchX, .pitchY(24'h001000),
		.inPixelsPerLine(ppl), .inLinesPerFrame(16'h0002), .outPixelsPerLine(16'h0004),
		.outLinesPerFrame(16'h0002), .pixIn, .pixInFrameStart, .pixInLineStart, .pixInValid,
		.pixInReady, .pixOut, .pixOutFrameStart, .pixOutLineStart, .pixOutValid, .pixOutReady);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic first(input int n, input int period);
		return n % period == 0;
	endfunction : first
	// Nearest source pixel for output n; rows map one to one (unit y pitch)
	function automatic logic [23:0] expPix(input int n, input int ppl, input int px);
		return 24'(((n % 8 / 4) * ppl + (n % 4) * px / 4096) * 24'h010101);
	endfunction : expPix
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
		end
	endtask : check
	task automatic frame(input logic mk);
		mark <= mk;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk_sys);
			if (!busy) return;
		end
		n_fail++;
		summarize();
	endtask : frame
	// Seeded sink stalls and source gaps
	always @(posedge clk_sys) begin
		seed = xs(seed);
		pixOutReady <= seed[3] | seed[7];
		gap <= seed[11] & seed[2];
	end
	// Output sync marking, 4 pixels a line and 8 a frame
	always @(posedge clk_sys) if (pixOutValid && pixOutReady) begin
		check(pixOut, expPix(nOut, ppl, pitchX));
		check(pixOutLineStart, first(nOut, 4));
		check(pixOutFrameStart, first(nOut, 8));
		nOut++;
		nFs += pixOutFrameStart;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				// Halve across with new geometry, applied under reset
				reset_n <= 1'b0;
				ppl <= 16'h0008;
				pitchX <= 24'h002000;
				repeat (2) @(posedge clk_sys);
				reset_n <= 1'b1;
			end
			frame(1'b0);
			repeat (30) @(posedge clk_sys);
			check(nOut, m * 24);
			repeat (3) frame(1'b1);
			for (int i = 0; i < 4000 && nOut < m * 24 + 24; i++) @(posedge clk_sys);
			// Output never completed: count it and report at once
			if (nOut < m * 24 + 24) begin
				n_fail++;
				summarize();
			end
			repeat (20) @(posedge clk_sys);
			check(nOut, m * 24 + 24);
			check(nFs, m * 3 + 3);
		end
		summarize();
	end
endmodule : video_scaler_stream_port_bench
`default_nettype wire
